// [rtl/srde_consts.vh]
// Constants for the split ring descriptor engine.
`ifndef SRDE_CONSTS_VH
`define SRDE_CONSTS_VH
// ----------------------------------------
// Register byte offsets on the Avalon-MM slave.
// ----------------------------------------
`define SRDE_REG_CTRL      6'h00
`define SRDE_REG_QSIZE     6'h04
`define SRDE_REG_DESC_LO   6'h08
`define SRDE_REG_DESC_HI   6'h0c
`define SRDE_REG_AVAIL_LO  6'h10
`define SRDE_REG_AVAIL_HI  6'h14
`define SRDE_REG_USED_LO   6'h18
`define SRDE_REG_USED_HI   6'h1c
`define SRDE_REG_STATUS    6'h20
`define SRDE_REG_USED_IDX  6'h24
// ----------------------------------------
// Control and status bit positions.
// ----------------------------------------
`define SRDE_CTRL_EN       0
`define SRDE_CTRL_EVIDX    1
`define SRDE_CTRL_INDIR    2
`define SRDE_ST_BUSY       0
`define SRDE_ST_ERR        1
// ----------------------------------------
// Descriptor flag bits and ring layout.
// ----------------------------------------
`define SRDE_F_NEXT        0
`define SRDE_F_WRITE       1
`define SRDE_F_INDIRECT    2
`define SRDE_NO_NOTIFY     16'h0001
`define SRDE_RING_HDR      64'h0000000000000004
`define SRDE_WORD_STEP     64'h0000000000000004
`define SRDE_QSIZE_RST     16'h0100
`endif

// [rtl/srde_engine.v]
// Split ring descriptor engine: chain walker, used-ring writer, notifier.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "srde_consts.vh"
module srde_engine (
	input  wire        core_clk_in,         // Core clock, 200 MHz.
	input  wire        rst_b_in,            // Asynchronous reset, active low.
	input  wire [5:0]  avs_address_in,      // Register byte address.
	input  wire        avs_read_in,         // Register read request.
	input  wire        avs_write_in,        // Register write request.
	input  wire [31:0] avs_writedata_in,    // Register write data.
	input  wire [3:0]  avs_byteenable_in,   // Byte lanes of a write.
	output wire [31:0] avs_readdata_out,    // Register read data.
	output wire        avs_waitrequest_out, // Stall of the register request.
	output wire        mem_req_out,         // Guest memory request, held to ack.
	output wire        mem_we_out,          // Memory request is a write.
	output wire [63:0] mem_addr_out,        // Aligned guest-physical byte address.
	output wire [31:0] mem_wdata_out,       // Memory write word.
	input  wire        mem_ack_in,          // Memory request done.
	input  wire [31:0] mem_rdata_in,        // Memory read word, valid with ack.
	output wire        seg_valid_out,       // A buffer segment is offered.
	output wire [63:0] seg_addr_out,        // Segment start address.
	output wire [31:0] seg_len_out,         // Segment length in bytes.
	output wire        seg_dev_writes_out,  // Segment is device-writable.
	input  wire        seg_ready_in,        // Client took the segment.
	output wire        done_ready_out,      // Engine waits for the byte count.
	input  wire        done_valid_in,       // Client finished the chain.
	input  wire [31:0] done_bytes_in,       // Bytes the client wrote.
	output wire        notify_out           // One-cycle used-buffer notification.
);
	// ----------------------------------------
	// States.
	// ----------------------------------------
	localparam [3:0] S_IDLE = 4'h0; // Polling is paused between checks.
	localparam [3:0] S_AHDR = 4'h1; // Reading available flags and idx.
	localparam [3:0] S_AENT = 4'h2; // Reading one available ring entry.
	localparam [3:0] S_DRD  = 4'h3; // Reading the four descriptor words.
	localparam [3:0] S_DCHK = 4'h4; // Deciding what the descriptor is.
	localparam [3:0] S_SEG  = 4'h5; // Offering a segment to the client.
	localparam [3:0] S_DONE = 4'h6; // Waiting for the written byte count.
	localparam [3:0] S_UID  = 4'h7; // Writing the used element head.
	localparam [3:0] S_ULEN = 4'h8; // Writing the used element length.
	localparam [3:0] S_UIDX = 4'h9; // Writing the used position counter.
	localparam [3:0] S_NRD  = 4'ha; // Reading the suppression word.

	// ----------------------------------------
	// Registers.
	// ----------------------------------------
	reg [3:0]  state_ff;      // Engine state.
	reg [2:0]  ctrl_ff;       // Enable, event index, indirect feature.
	reg [15:0] qsize_ff;      // Queue size, a power of two.
	reg [63:0] desc_base_ff;  // Descriptor table base.
	reg [63:0] avail_base_ff; // Available ring base.
	reg [63:0] used_base_ff;  // Used ring base.
	reg        err_ff;        // Sticky malformed-chain flag.
	reg [15:0] last_avail_ff; // Next available entry to consume.
	reg [15:0] used_idx_ff;   // Used position counter.
	reg        ack_ff;        // Register access answered this cycle.
	reg [31:0] rdata_ff;      // Register read data.
	reg        mem_req_ff;    // Memory request pending.
	reg        mem_we_ff;     // Pending request is a write.
	reg [63:0] mem_addr_ff;   // Pending request address.
	reg [31:0] mem_wdata_ff;  // Pending write word.
	reg [1:0]  wc_ff;         // Descriptor word counter.
	reg [15:0] head_ff;       // Chain head index.
	reg [15:0] didx_ff;       // Descriptor being fetched.
	reg        in_ind_ff;     // Walking an indirect table.
	reg [63:0] ind_base_ff;   // Indirect table start.
	reg [27:0] ind_n_ff;      // Indirect table entries.
	reg [16:0] count_ff;      // Descriptors visited in this chain.
	reg [63:0] d_addr_ff;     // Descriptor address field.
	reg [31:0] d_len_ff;      // Descriptor length field.
	reg [15:0] d_flags_ff;    // Descriptor flags.
	reg [15:0] d_next_ff;     // Descriptor link.
	reg [31:0] wcap_ff;       // Writable capacity of the chain.
	reg [31:0] ulen_ff;       // Length for the used element.
	reg        seg_valid_ff;  // Segment offered.
	reg        notify_ff;     // Notification pulse.

	// ----------------------------------------
	// Helper functions.
	// ----------------------------------------
	// Picks the 16-bit half of a word named by address bit 1.
	function [15:0] half_sel;
		input [31:0] w;
		input        hi;
		begin
			half_sel = hi ? w[31:16] : w[15:0];
		end
	endfunction

	// Applies byte enables to a register write.
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  be;
		integer      i;
		begin
			be_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					be_merge[i*8 +: 8] = wd[i*8 +: 8];
				end
			end
		end
	endfunction

	// Byte address of a 16-bit ring slot after the 4-byte ring header.
	function [63:0] slot16;
		input [63:0] base;
		input [15:0] slot;
		begin
			slot16 = base + `SRDE_RING_HDR + {47'h0, slot, 1'b0};
		end
	endfunction

	// ----------------------------------------
	// Derived values.
	// ----------------------------------------
	wire [15:0] qmask     = qsize_ff - 16'h0001;           // Index mask for slots.
	wire [63:0] ent_addr  = slot16(avail_base_ff, last_avail_ff & qmask);
	wire [63:0] uevt_addr = slot16(avail_base_ff, qsize_ff);  // used_event slot.
	wire [63:0] uel_addr  = used_base_ff + `SRDE_RING_HDR +
		{45'h0, used_idx_ff & qmask, 3'h0};               // Used element slot.
	wire [63:0] tbl_base  = in_ind_ff ? ind_base_ff : desc_base_ff;
	wire        mem_done  = mem_req_ff & mem_ack_in;      // Memory answer.
	wire        is_ind    = d_flags_ff[`SRDE_F_INDIRECT];
	wire        has_next  = d_flags_ff[`SRDE_F_NEXT];
	wire        busy      = (state_ff != S_IDLE);
	wire        reg_req   = avs_read_in | avs_write_in;

	// ----------------------------------------
	// Register read mux.
	// ----------------------------------------
	// Unmapped offsets read as zero.
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (avs_address_in)
			`SRDE_REG_CTRL:     rd_mux = {29'h0, ctrl_ff};
			`SRDE_REG_QSIZE:    rd_mux = {16'h0, qsize_ff};
			`SRDE_REG_DESC_LO:  rd_mux = desc_base_ff[31:0];
			`SRDE_REG_DESC_HI:  rd_mux = desc_base_ff[63:32];
			`SRDE_REG_AVAIL_LO: rd_mux = avail_base_ff[31:0];
			`SRDE_REG_AVAIL_HI: rd_mux = avail_base_ff[63:32];
			`SRDE_REG_USED_LO:  rd_mux = used_base_ff[31:0];
			`SRDE_REG_USED_HI:  rd_mux = used_base_ff[63:32];
			`SRDE_REG_STATUS:   rd_mux = {last_avail_ff, 14'h0, err_ff, busy};
			`SRDE_REG_USED_IDX: rd_mux = {16'h0, used_idx_ff};
			default:            rd_mux = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// Avalon-MM slave.
	// ----------------------------------------
	// Every access waits one cycle; the write lands at the answering edge.
	wire wr_now = avs_write_in & ack_ff;
	wire err_set;  // Engine flags a malformed chain.
	// Control and queue size words after the byte enables, cut to width on purpose below.
	wire [31:0] ctrl_mrg  = be_merge({29'h0, ctrl_ff}, avs_writedata_in, avs_byteenable_in);
	wire [31:0] qsize_mrg = be_merge({16'h0, qsize_ff}, avs_writedata_in, avs_byteenable_in);
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_ff        <= 1'b0;
			rdata_ff      <= 32'h00000000;
			ctrl_ff       <= 3'h0;
			qsize_ff      <= `SRDE_QSIZE_RST;
			desc_base_ff  <= 64'h0000000000000000;
			avail_base_ff <= 64'h0000000000000000;
			used_base_ff  <= 64'h0000000000000000;
			err_ff        <= 1'b0;
		end else begin
			ack_ff <= reg_req & ~ack_ff;
			if (reg_req & ~ack_ff) begin
				rdata_ff <= rd_mux;
			end
			// Setting by the engine wins over a clear in the same cycle.
			if (err_set) begin
				err_ff <= 1'b1;
			end else if (wr_now && avs_address_in == `SRDE_REG_STATUS &&
				avs_byteenable_in[0] && avs_writedata_in[`SRDE_ST_ERR]) begin
				err_ff <= 1'b0;
			end
			if (wr_now) begin
				case (avs_address_in)
					`SRDE_REG_CTRL:     ctrl_ff <= ctrl_mrg[2:0];
					`SRDE_REG_QSIZE:    qsize_ff <= qsize_mrg[15:0];
					`SRDE_REG_DESC_LO:  desc_base_ff[31:0] <= be_merge(
						desc_base_ff[31:0], avs_writedata_in, avs_byteenable_in);
					`SRDE_REG_DESC_HI:  desc_base_ff[63:32] <= be_merge(
						desc_base_ff[63:32], avs_writedata_in, avs_byteenable_in);
					`SRDE_REG_AVAIL_LO: avail_base_ff[31:0] <= be_merge(
						avail_base_ff[31:0], avs_writedata_in, avs_byteenable_in);
					`SRDE_REG_AVAIL_HI: avail_base_ff[63:32] <= be_merge(
						avail_base_ff[63:32], avs_writedata_in, avs_byteenable_in);
					`SRDE_REG_USED_LO:  used_base_ff[31:0] <= be_merge(
						used_base_ff[31:0], avs_writedata_in, avs_byteenable_in);
					`SRDE_REG_USED_HI:  used_base_ff[63:32] <= be_merge(
						used_base_ff[63:32], avs_writedata_in, avs_byteenable_in);
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Chain walker and used-ring writer.
	// ----------------------------------------
	// Malformed: too many descriptors, nested or unnegotiated indirect, bad link.
	wire too_long  = (count_ff >= {1'b0, qsize_ff});
	wire bad_ind   = is_ind & (in_ind_ff | ~ctrl_ff[`SRDE_CTRL_INDIR]);
	wire bad_link  = in_ind_ff & ({12'h0, d_next_ff} >= ind_n_ff);
	assign err_set = (state_ff == S_DCHK) & (too_long | bad_ind) |
		(state_ff == S_SEG) & seg_ready_in & has_next & bad_link;

	// Issues one memory access.
	task mem_go;
		input        we;
		input [63:0] addr;
		input [31:0] wd;
		begin
			mem_req_ff   <= 1'b1;
			mem_we_ff    <= we;
			mem_addr_ff  <= {addr[63:2], 2'b00};
			mem_wdata_ff <= wd;
		end
	endtask

	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff      <= S_IDLE;
			last_avail_ff <= 16'h0000;
			used_idx_ff   <= 16'h0000;
			mem_req_ff    <= 1'b0;
			mem_we_ff     <= 1'b0;
			mem_addr_ff   <= 64'h0000000000000000;
			mem_wdata_ff  <= 32'h00000000;
			wc_ff         <= 2'h0;
			head_ff       <= 16'h0000;
			didx_ff       <= 16'h0000;
			in_ind_ff     <= 1'b0;
			ind_base_ff   <= 64'h0000000000000000;
			ind_n_ff      <= 28'h0000000;
			count_ff      <= 17'h00000;
			d_addr_ff     <= 64'h0000000000000000;
			d_len_ff      <= 32'h00000000;
			d_flags_ff    <= 16'h0000;
			d_next_ff     <= 16'h0000;
			wcap_ff       <= 32'h00000000;
			ulen_ff       <= 32'h00000000;
			seg_valid_ff  <= 1'b0;
			notify_ff     <= 1'b0;
		end else begin
			notify_ff <= 1'b0;
			if (mem_done) begin
				mem_req_ff <= 1'b0;
			end
			case (state_ff)
				S_IDLE: begin
					// Poll the available header while enabled.
					if (ctrl_ff[`SRDE_CTRL_EN]) begin
						mem_go(1'b0, avail_base_ff, 32'h00000000);
						state_ff <= S_AHDR;
					end
				end
				S_AHDR: if (mem_done) begin
					// New heads are fetched at once when idx moved on.
					if (mem_rdata_in[31:16] != last_avail_ff) begin
						mem_go(1'b0, ent_addr, 32'h00000000);
						state_ff <= S_AENT;
					end else begin
						state_ff <= S_IDLE;
					end
				end
				S_AENT: if (mem_done) begin
					head_ff   <= half_sel(mem_rdata_in, ent_addr[1]);
					didx_ff   <= half_sel(mem_rdata_in, ent_addr[1]);
					in_ind_ff <= 1'b0;
					count_ff  <= 17'h00000;
					wcap_ff   <= 32'h00000000;
					wc_ff     <= 2'h0;
					mem_go(1'b0, desc_base_ff +
						{44'h0, half_sel(mem_rdata_in, ent_addr[1]), 4'h0}, 32'h00000000);
					state_ff  <= S_DRD;
				end
				S_DRD: if (mem_done) begin
					// Word order: address low, address high, length, flags and link.
					case (wc_ff)
						2'h0: d_addr_ff[31:0]  <= mem_rdata_in;
						2'h1: d_addr_ff[63:32] <= mem_rdata_in;
						2'h2: d_len_ff         <= mem_rdata_in;
						default: begin
							d_flags_ff <= mem_rdata_in[15:0];
							d_next_ff  <= mem_rdata_in[31:16];
						end
					endcase
					if (wc_ff == 2'h3) begin
						state_ff <= S_DCHK;
					end else begin
						wc_ff <= wc_ff + 2'h1;
						mem_go(1'b0, mem_addr_ff + `SRDE_WORD_STEP, 32'h00000000);
					end
				end
				S_DCHK: begin
					count_ff <= count_ff + 17'h00001;
					if (too_long | bad_ind) begin
						ulen_ff  <= 32'h00000000;
						state_ff <= S_UID;
					end else if (is_ind) begin
						// Enter the table at entry 0; its own write flag is ignored.
						in_ind_ff   <= 1'b1;
						ind_base_ff <= d_addr_ff;
						ind_n_ff    <= d_len_ff[31:4];
						didx_ff     <= 16'h0000;
						wc_ff       <= 2'h0;
						mem_go(1'b0, d_addr_ff, 32'h00000000);
						state_ff    <= S_DRD;
					end else begin
						if (d_flags_ff[`SRDE_F_WRITE]) begin
							wcap_ff <= wcap_ff + d_len_ff;
						end
						seg_valid_ff <= 1'b1;
						state_ff     <= S_SEG;
					end
				end
				S_SEG: if (seg_ready_in) begin
					seg_valid_ff <= 1'b0;
					if (!has_next) begin
						state_ff <= S_DONE;
					end else if (bad_link) begin
						ulen_ff  <= 32'h00000000;
						state_ff <= S_UID;
					end else begin
						didx_ff <= d_next_ff;
						wc_ff   <= 2'h0;
						mem_go(1'b0, tbl_base + {44'h0, d_next_ff, 4'h0}, 32'h00000000);
						state_ff <= S_DRD;
					end
				end
				S_DONE: if (done_valid_in) begin
					// Report no more than the chain could hold.
					ulen_ff  <= (done_bytes_in > wcap_ff) ? wcap_ff : done_bytes_in;
					state_ff <= S_UID;
				end
				S_UID: begin
					if (!mem_req_ff) begin
						mem_go(1'b1, uel_addr, {16'h0, head_ff});
					end else if (mem_done) begin
						mem_go(1'b1, uel_addr + `SRDE_WORD_STEP, ulen_ff);
						state_ff <= S_ULEN;
					end
				end
				S_ULEN: if (mem_done) begin
					// The counter moves only after the length is stored.
					mem_go(1'b1, used_base_ff,
						{used_idx_ff + 16'h0001, 16'h0000});
					state_ff <= S_UIDX;
				end
				S_UIDX: if (mem_done) begin
					used_idx_ff   <= used_idx_ff + 16'h0001;
					last_avail_ff <= last_avail_ff + 16'h0001;
					mem_go(1'b0, ctrl_ff[`SRDE_CTRL_EVIDX] ? uevt_addr : avail_base_ff,
						32'h00000000);
					state_ff <= S_NRD;
				end
				S_NRD: if (mem_done) begin
					// used_idx_ff already advanced, so compare the previous value.
					if (ctrl_ff[`SRDE_CTRL_EVIDX]) begin
						notify_ff <= (half_sel(mem_rdata_in, uevt_addr[1]) ==
							used_idx_ff - 16'h0001);
					end else begin
						notify_ff <= (mem_rdata_in[15:0] & `SRDE_NO_NOTIFY) == 16'h0000;
					end
					state_ff <= S_IDLE;
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign avs_waitrequest_out = reg_req & ~ack_ff;
	assign avs_readdata_out    = rdata_ff;
	assign mem_req_out         = mem_req_ff;
	assign mem_we_out          = mem_we_ff;
	assign mem_addr_out        = mem_addr_ff;
	assign mem_wdata_out       = mem_wdata_ff;
	assign seg_valid_out       = seg_valid_ff;
	assign seg_addr_out        = d_addr_ff;
	assign seg_len_out         = d_len_ff;
	// The client moves data only in the direction given here.
	assign seg_dev_writes_out  = d_flags_ff[`SRDE_F_WRITE];
	assign done_ready_out      = (state_ff == S_DONE);
	assign notify_out          = notify_ff;
endmodule
`default_nettype wire

// [verification/srde_engine_monitor.sv]
// Checker of the port timing of the split ring descriptor engine.
`timescale 1ns/1ps
`default_nettype none
module srde_engine_monitor (
	input wire logic        core_clk_in,
	input wire logic        rst_b_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic        avs_waitrequest_out,
	input wire logic        mem_req_out,
	input wire logic        mem_we_out,
	input wire logic [63:0] mem_addr_out,
	input wire logic [31:0] mem_wdata_out,
	input wire logic        mem_ack_in,
	input wire logic        seg_valid_out,
	input wire logic [63:0] seg_addr_out,
	input wire logic [31:0] seg_len_out,
	input wire logic        seg_dev_writes_out,
	input wire logic        seg_ready_in,
	input wire logic        notify_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	// ----------------------------------------
	// Steps of a memory and a segment handshake.
	// ----------------------------------------
	sequence s_mem_wait;
		mem_req_out && !mem_ack_in;
	endsequence
	sequence s_mem_held;
		mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out) && $stable(mem_wdata_out);
	endsequence
	sequence s_seg_held;
		seg_valid_out && $stable(seg_addr_out) && $stable(seg_len_out) && $stable(seg_dev_writes_out);
	endsequence
	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	a_wait_first: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
		else $error("waitrequest low on the first cycle of a request");
	a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=>
		!avs_waitrequest_out) else $error("register answer later than one cycle");
	a_mem_hold: assert property (s_mem_wait |=> s_mem_held)
		else $error("memory request changed before ack");
	a_mem_drop: assert property (mem_req_out && mem_ack_in |=> !mem_req_out ||
		$changed(mem_addr_out)) else $error("memory request repeated after ack");
	a_mem_align: assert property (mem_req_out |-> mem_addr_out[1:0] == 2'h0)
		else $error("memory address not word aligned");
	a_seg_hold: assert property (seg_valid_out && !seg_ready_in |=> s_seg_held)
		else $error("segment changed before accept");
	a_seg_drop: assert property (seg_valid_out && seg_ready_in |=> !seg_valid_out)
		else $error("segment offered again after accept");
	a_notify_pulse: assert property (notify_out |=> !notify_out)
		else $error("notification longer than one cycle");
	a_notify_cause: assert property (notify_out |-> $past(mem_ack_in))
		else $error("notification without a memory ack before it");
endmodule
bind srde_engine srde_engine_monitor u_mon (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_waitrequest_out(avs_waitrequest_out), .mem_req_out(mem_req_out),
	.mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
	.mem_ack_in(mem_ack_in), .seg_valid_out(seg_valid_out), .seg_addr_out(seg_addr_out),
	.seg_len_out(seg_len_out), .seg_dev_writes_out(seg_dev_writes_out),
	.seg_ready_in(seg_ready_in), .notify_out(notify_out));
`default_nettype wire

// [verification/srde_guest_mem.sv]
// Guest memory model holding the rings that the driver shares with the engine.
`timescale 1ns/1ps
`default_nettype none
module srde_guest_mem (
	input wire logic        core_clk_in,
	input wire logic        slow_in,   // Adds wait cycles before each ack.
	input wire logic        req_in,
	input wire logic        we_in,
	input wire logic [63:0] addr_in,
	input wire logic [31:0] wdata_in,
	output var logic        ack_out,
	output var logic [31:0] rdata_out,
	output var logic        bad_out    // Sticky: engine wrote a driver-owned word.
);
	logic [31:0] m [0:1023];           // Four kilobytes of guest memory.
	logic [1:0]  dly;                  // Wait cycles spent on this request.
	initial begin
		ack_out = 1'b0;
		rdata_out = 32'h0;
		bad_out = 1'b0;
		dly = 2'h0;
	end
	// Answers one request at a time; read data are scrambled outside acks.
	always @(posedge core_clk_in) begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (req_in && !ack_out) begin
			dly <= dly + 2'h1;
			if (!slow_in || dly == 2'h3) begin
				ack_out <= 1'b1;
				dly <= 2'h0;
				rdata_out <= m[addr_in[11:2]];
				if (we_in) begin
					m[addr_in[11:2]] <= wdata_in;
					// Only the used ring at 0x800 belongs to the engine.
					if (addr_in < 64'h800 || addr_in >= 64'h900) bad_out <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench of the split ring descriptor engine.
`timescale 1ns/1ps
`default_nettype none
`include "srde_consts.vh"
module tb;
	logic core_clk_in, rst_b_in, avs_read_in, avs_write_in, avs_waitrequest_out, slow;
	logic [5:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, mem_wdata_out, mem_rdata_in, q;
	logic mem_req_out, mem_we_out, mem_ack_in, bad, seg_valid_out, seg_dev_writes_out;
	logic seg_ready_in, done_ready_out, done_valid_in, notify_out;
	logic [63:0] mem_addr_out, seg_addr_out;
	logic [31:0] seg_len_out;
	logic [7:0] segs;                  // Direction of accepted segments, newest in bit 0.
	logic [31:0] slen, sadr;           // Summed segment lengths and last segment address.
	int nseg, ntf, fail_count, comparisons, cyc;
	srde_engine dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .mem_req_out(mem_req_out),
		.mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .seg_valid_out(seg_valid_out),
		.seg_addr_out(seg_addr_out), .seg_len_out(seg_len_out),
		.seg_dev_writes_out(seg_dev_writes_out), .seg_ready_in(seg_ready_in),
		.done_ready_out(done_ready_out), .done_valid_in(done_valid_in),
		.done_bytes_in(32'h14), .notify_out(notify_out));
	srde_guest_mem mem (.core_clk_in(core_clk_in), .slow_in(slow), .req_in(mem_req_out),
		.we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
		.ack_out(mem_ack_in), .rdata_out(mem_rdata_in), .bad_out(bad));
	// ----------------------------------------
	// Clock, client side and hang guard.
	// ----------------------------------------
	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	// The client accepts each segment and reports 20 written bytes when asked.
	always @(posedge core_clk_in) begin
		seg_ready_in <= seg_valid_out && !seg_ready_in;
		done_valid_in <= done_ready_out && !done_valid_in;
		if (seg_valid_out && seg_ready_in) begin
			segs <= {segs[6:0], seg_dev_writes_out};
			nseg <= nseg + 1;
			slen <= slen + seg_len_out;
			sadr <= seg_addr_out[31:0];
		end
		if (notify_out) ntf <= ntf + 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count = fail_count + 1;
			close_out();
		end
	end
	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic close_out();
		if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One Avalon-MM access; waitrequest and read data are taken at the same rising edge.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_address_in <= a;
		avs_writedata_in <= d;
		do begin
			@(posedge core_clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	// Descriptor i of the table at 0x000, or entry i of a table at base b.
	task automatic desc(input int b, input int i, input logic [31:0] a, input logic [31:0] l,
		input logic [15:0] f, input logic [15:0] nx);
		mem.m[b/4 + 4*i] = a;
		mem.m[b/4 + 4*i + 1] = 32'h0;
		mem.m[b/4 + 4*i + 2] = l;
		mem.m[b/4 + 4*i + 3] = {nx, f};
	endtask
	// Places a head in slot s, then exposes it by raising the index; waits for the used index.
	task automatic post(input int s, input logic [15:0] head, input logic [15:0] idx,
		input logic [15:0] fl);
		int n;
		if (s % 2) mem.m[32'h101 + s/2][31:16] = head;
		else mem.m[32'h101 + s/2][15:0] = head;
		mem.m[32'h100] = {idx, fl};
		n = 0;
		while (mem.m[32'h200][31:16] !== idx && n < 3000) begin
			@(posedge core_clk_in);
			n++;
		end
		repeat (12) @(posedge core_clk_in);
		chk("used_idx", {16'h0, mem.m[32'h200][31:16]}, {16'h0, idx});
	endtask
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_regs();
		bus(1'b0, `SRDE_REG_QSIZE, 32'h0);
		chk("qsize_reset", q, 32'h100);
		bus(1'b0, 6'h3c, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, `SRDE_REG_QSIZE, 32'h4);
		bus(1'b1, `SRDE_REG_AVAIL_LO, 32'h400);
		bus(1'b1, `SRDE_REG_USED_LO, 32'h800);
		bus(1'b1, `SRDE_REG_CTRL, 32'h5);
	endtask
	// Readable then writable descriptor; flags 0 ask for a notification.
	task automatic t_plain();
		desc(0, 0, 32'h300, 32'h8, 16'h1, 16'h1);
		desc(0, 1, 32'h340, 32'h10, 16'h2, 16'h0);
		post(0, 16'h0, 16'h1, 16'h0);
		chk("segs", {nseg[29:0], segs[1:0]}, {30'h2, 2'b01});
		chk("seg_len", slen, 32'h18);
		chk("seg_addr", sadr, 32'h340);
		chk("id", mem.m[32'h201], 32'h0);
		chk("len", mem.m[32'h202], 32'h10);
		chk("notify", ntf, 32'h1);
	endtask
	// Plain descriptor, then one indirect with a stray write flag; flags 1 suppress.
	task automatic t_indirect();
		desc(0, 2, 32'h380, 32'h4, 16'h1, 16'h3);
		desc(0, 3, 32'h200, 32'h20, 16'h6, 16'h0);
		desc(32'h200, 0, 32'h3a0, 32'h8, 16'h1, 16'h1);
		desc(32'h200, 1, 32'h3c0, 32'hc, 16'h2, 16'h0);
		post(1, 16'h2, 16'h2, 16'h1);
		chk("segs", {nseg[28:0], segs[2:0]}, {29'h5, 3'b001});
		chk("id", mem.m[32'h203], 32'h2);
		chk("len", mem.m[32'h204], 32'hc);
		chk("notify", ntf, 32'h1);
	endtask
	// Event index: flag bit ignored, notify only when old used index met the threshold.
	task automatic t_event();
		slow <= 1'b1;
		bus(1'b1, `SRDE_REG_CTRL, 32'h7);
		mem.m[32'h103][15:0] = 16'h2;
		post(2, 16'h0, 16'h3, 16'h1);
		chk("notify", ntf, 32'h2);
		post(3, 16'h0, 16'h4, 16'h1);
		chk("notify", ntf, 32'h2);
		chk("len", mem.m[32'h208], 32'h10);
	endtask
	// A chain linking to itself is cut off and flagged.
	task automatic t_loop();
		desc(0, 3, 32'h380, 32'h4, 16'h1, 16'h3);
		post(0, 16'h3, 16'h5, 16'h0);
		chk("loop_len", mem.m[32'h202], 32'h0);
		bus(1'b0, `SRDE_REG_STATUS, 32'h0);
		chk("err", {31'h0, q[`SRDE_ST_ERR]}, 32'h1);
		bus(1'b1, `SRDE_REG_STATUS, 32'h2);
		bus(1'b0, `SRDE_REG_STATUS, 32'h0);
		chk("err_clr", {31'h0, q[`SRDE_ST_ERR]}, 32'h0);
		chk("bad_write", {31'h0, bad}, 32'h0);
	endtask
	initial begin
		{avs_read_in, avs_write_in, seg_ready_in, done_valid_in, slow, rst_b_in} = 6'h0;
		{avs_address_in, avs_writedata_in, segs, slen, sadr} = 110'h0;
		{nseg, ntf, fail_count, comparisons, cyc} = '0;
		for (int i = 0; i < 1024; i++) mem.m[i] = 32'h0;
		repeat (2) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		t_regs();
		t_plain();
		t_indirect();
		t_event();
		t_loop();
		close_out();
	end
endmodule
`default_nettype wire
